/* core/csw_capture_window.sv */
// Behaviour
// RULE_01 - Mode register bit 15 reads current field, 0 odd, 1 even.
// RULE_02 - Bit 14 enables quarter-half-quarter horizontal filter on raw data.
// RULE_03 - Bits 13-12 pick raw, 16-bit or 8-bit YCbCr; reset to 2.
// RULE_04 - Raw mode only: right-shift stored data by 0 to 4 bits.
// RULE_05 - Bit 7 selects progressive or interlaced field handling.
// RULE_06 - Bit 6 inverts incoming sensor data bitwise.
// RULE_07 - Bit 5 with enable gates writes by external write enable and syncs.
// RULE_08 - Bits 4, 3, 2 set field, hsync, vsync polarity; 1 is negative.
// RULE_09 - Bit 1 field pin direction, bit 0 both sync pins; 1 drives.
// RULE_10 - Generated hsync lasts width plus one pixel clocks.
// RULE_11 - Generated vsync lasts width plus one lines.
// RULE_12 - Generated line period is pixels-per-line plus one pixel clocks.
// RULE_13 - Generated frame period is half-lines plus one, halved, lines.
// RULE_14 - Each line's capture starts at start-pixel after hsync start.
// RULE_15 - Capture length plus one pixels, truncated to multiple of 16.
// RULE_16 - Capture starts at per-field start line after vsync start.
// RULE_17 - Exactly line-count plus one lines are captured per field.
// RULE_18 - Pixel retain mask, high byte even lines, low byte odd lines.
// RULE_19 - Line retain mask of eight bits, repeating every eight lines.
// RULE_20 - Address-decrement bit mirrors each stored line.
// RULE_21 - Filter, timing, window, cull and size settings apply at vsync.
// RULE_22 - Software writes zero to reserved bits.
// RULE_23 - Sync enable starts generator or locks to external syncs.
// RULE_24 - Data write enable gates storing, taken at vsync.
// RULE_25 - Line base advances by line offset times 32 bytes.
// RULE_26 - Window counters restart at active sync edges after polarity.
// RULE_27 - Cull mask positions restart at window's first pixel and line.
//
// Purpose: Sync timing, capture window and cull logic of a sensor front end
// Assumes: Pixel clock well below half of i_clock; sampled, not used as clock
// Notes:   Memory address counts 16-bit pixels from zero at each vsync
//
// Chosen here: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module csw_capture_window #(
  parameter int ADDR_W = 24,
  parameter int DATA_W = 16
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst,
  input  wire logic [7:0]        i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [31:0]       i_avs_writedata,
  output logic      [31:0]       o_avs_readdata,
  output logic                   o_avs_waitrequest,
  input  wire logic              i_pclk,
  input  wire logic [DATA_W-1:0] i_pix_data,
  input  wire logic              i_ext_wen,
  input  wire logic              i_hsync,
  output logic                   o_hsync,
  output logic                   o_hsync_oe,
  input  wire logic              i_vsync,
  output logic                   o_vsync,
  output logic                   o_vsync_oe,
  input  wire logic              i_field_id,
  output logic                   o_field_id,
  output logic                   o_field_id_oe,
  output logic                   o_mem_valid,
  output logic      [DATA_W-1:0] o_mem_data,
  output logic      [ADDR_W-1:0] o_mem_addr
);

  typedef struct packed {
    logic [2:0]              pclk_s;
    logic [1:0]              hs_s;
    logic [1:0]              vs_s;
    logic [1:0]              fid_s;
    logic [1:0]              wen_s;
    logic [DATA_W-1:0]       d_s1;
    logic [DATA_W-1:0]       d_s2;
    logic                    wait_q;
    logic [31:0]             rdata;
    logic                    sync_generator_enable;
    csw_pkg::csw_mode_t      mode;
    csw_pkg::csw_timing_t    sh;
    csw_pkg::csw_timing_t    act;
    logic                    hs_prev;
    logic                    vs_prev;
    logic                    field;
    logic [15:0]             hcnt;
    logic [15:0]             vhalf;
    logic                    gen_fid;
    logic [15:0]             hpos;
    logic [15:0]             vline;
    logic                    line_used;
    logic [ADDR_W-1:0]       base;
    logic [14:0]             wpos;
    logic [DATA_W-1:0]       p1;
    logic [DATA_W-1:0]       p2;
    logic                    mvalid;
    logic [DATA_W-1:0]       mdata;
    logic [ADDR_W-1:0]       maddr;
    logic                    o_hs;
    logic                    o_vs;
    logic                    o_fid;
    logic                    oe_s;
    logic                    oe_f;
  } csw_state_t;

  csw_state_t         st_q;
  csw_state_t         st_d;
  csw_pkg::csw_avs_req_t req;
  logic               pix_en;
  logic               gen_on;
  logic               gen_hs;
  logic               gen_vs;
  logic               hs_act;
  logic               vs_act;
  logic               hs_edge;
  logic               vs_edge;
  logic               latch;
  logic               bus_take;
  logic [15:0]        npix;
  logic [15:0]        hwin;
  logic [15:0]        lwin;
  logic [14:0]        slv;
  logic               in_h;
  logic               in_v;
  logic [7:0]         hmask;
  logic               keep;
  logic               gate_ok;
  logic               wr;
  logic [DATA_W-1:0]  inv_d;
  logic [DATA_W+1:0]  fsum;
  logic [DATA_W-1:0]  raw_d;
  logic [2:0]         amt;
  logic [15:0]        off;

  assign req = '{address: i_avs_address, read: i_avs_read, write: i_avs_write, writedata: i_avs_writedata};

  function automatic logic [31:0] read_mux(input csw_state_t s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      csw_pkg::OFF_SYNC_ENABLE: v = 32'({s.sh.memory_write_enable, s.sync_generator_enable});
      // RULE_01 field status readback
      csw_pkg::OFF_MODE:        v = 32'({s.field, s.sh.lpf, s.mode});
      csw_pkg::OFF_HS_WIDTH:    v = 32'(s.sh.hsync_pulse_width);
      csw_pkg::OFF_VS_WIDTH:    v = 32'(s.sh.vsync_pulse_width);
      csw_pkg::OFF_PIX_LINE:    v = 32'(s.sh.line_period_count);
      csw_pkg::OFF_HALF_LINES:  v = 32'(s.sh.frame_half_line_count);
      csw_pkg::OFF_START_PIX:   v = 32'(s.sh.capture_start_pixel);
      csw_pkg::OFF_LINE_LEN:    v = 32'(s.sh.capture_line_length);
      csw_pkg::OFF_START_LN0:   v = 32'(s.sh.start_line_field_zero);
      csw_pkg::OFF_START_LN1:   v = 32'(s.sh.start_line_field_one);
      csw_pkg::OFF_LINE_CNT:    v = 32'(s.sh.capture_line_count);
      csw_pkg::OFF_HCULL:       v = 32'(s.sh.horizontal_cull_mask);
      csw_pkg::OFF_VCULL:       v = 32'(s.sh.line_cull_mask);
      csw_pkg::OFF_LINE_SIZE:   v = 32'({s.sh.address_decrement, s.sh.lofst});
      default:                  v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  always_comb begin
    st_d = st_q;
    // Pin synchronisers; stage one feeds stage two only
    st_d.pclk_s = {st_q.pclk_s[1:0], i_pclk};
    st_d.hs_s   = {st_q.hs_s[0], i_hsync};
    st_d.vs_s   = {st_q.vs_s[0], i_vsync};
    st_d.fid_s  = {st_q.fid_s[0], i_field_id};
    st_d.wen_s  = {st_q.wen_s[0], i_ext_wen};
    st_d.d_s1   = i_pix_data;
    st_d.d_s2   = st_q.d_s1;
    pix_en      = st_q.pclk_s[1] & ~st_q.pclk_s[2];

    // Bus slave: one wait cycle, then the access completes
    st_d.wait_q = !((req.read || req.write) && st_q.wait_q);
    bus_take    = (req.read || req.write) && !st_q.wait_q;
    if ((req.read || req.write) && st_q.wait_q) begin
      st_d.rdata = read_mux(st_q, req.address);
    end
    // RULE_22 reserved bits are simply not stored
    if (bus_take && req.write) begin
      unique case (req.address)
        csw_pkg::OFF_SYNC_ENABLE: begin
          st_d.sync_generator_enable    = req.writedata[csw_pkg::SYNC_SYNC_GENERATOR_ENABLE_BIT];
          st_d.sh.memory_write_enable = req.writedata[csw_pkg::SYNC_MEMORY_WRITE_ENABLE_BIT];
        end
        csw_pkg::OFF_MODE: begin
          st_d.mode     = req.writedata[13:0];
          st_d.mode.pad = 1'b0;
          st_d.sh.lpf   = req.writedata[csw_pkg::MODE_FILTER_BIT];
        end
        csw_pkg::OFF_HS_WIDTH:   st_d.sh.hsync_pulse_width  = req.writedata[11:0];
        csw_pkg::OFF_VS_WIDTH:   st_d.sh.vsync_pulse_width  = req.writedata[11:0];
        csw_pkg::OFF_PIX_LINE:   st_d.sh.line_period_count = req.writedata[15:0];
        csw_pkg::OFF_HALF_LINES: st_d.sh.frame_half_line_count = req.writedata[15:0];
        csw_pkg::OFF_START_PIX:  st_d.sh.capture_start_pixel  = req.writedata[14:0];
        csw_pkg::OFF_LINE_LEN:   st_d.sh.capture_line_length  = req.writedata[14:0];
        csw_pkg::OFF_START_LN0:  st_d.sh.start_line_field_zero = req.writedata[14:0];
        csw_pkg::OFF_START_LN1:  st_d.sh.start_line_field_one = req.writedata[14:0];
        csw_pkg::OFF_LINE_CNT:   st_d.sh.capture_line_count  = req.writedata[14:0];
        csw_pkg::OFF_HCULL:      st_d.sh.horizontal_cull_mask = req.writedata[15:0];
        csw_pkg::OFF_VCULL:      st_d.sh.line_cull_mask = req.writedata[7:0];
        csw_pkg::OFF_LINE_SIZE: begin
          st_d.sh.address_decrement  = req.writedata[csw_pkg::SIZE_DECR_BIT];
          st_d.sh.lofst = req.writedata[11:0];
        end
        default: st_d.sync_generator_enable = st_q.sync_generator_enable;
      endcase
    end

    // RULE_23 generator runs only when enabled and driving
    gen_on = st_q.sync_generator_enable && st_q.mode.sdir;
    // RULE_10 hsync width plus one
    gen_hs = gen_on && (st_q.hcnt <= 16'(st_q.act.hsync_pulse_width));
    // RULE_11 vsync width plus one lines, in half lines
    gen_vs = gen_on && ({1'b0, st_q.vhalf} <= 17'({st_q.act.vsync_pulse_width, 1'b1}));
    if (!gen_on) begin
      st_d.hcnt  = 16'h0000;
      st_d.vhalf = 16'h0000;
    end else if (pix_en) begin
      // RULE_12 line period plus one
      st_d.hcnt = (st_q.hcnt >= st_q.act.line_period_count) ? 16'h0000 : st_q.hcnt + 16'h0001;
      // RULE_13 frame in half lines plus one
      if (st_q.hcnt == st_q.act.line_period_count || st_q.hcnt == (st_q.act.line_period_count >> 1)) begin
        st_d.vhalf = (st_q.vhalf >= st_q.act.frame_half_line_count) ? 16'h0000 : st_q.vhalf + 16'h0001;
      end
    end

    // RULE_08 polarity applied to input syncs
    hs_act = st_q.mode.sdir ? gen_hs : (st_q.hs_s[1] ^ st_q.mode.hpol);
    vs_act = st_q.mode.sdir ? gen_vs : (st_q.vs_s[1] ^ st_q.mode.vpol);
    hs_edge = pix_en && st_q.sync_generator_enable && hs_act && !st_q.hs_prev;
    vs_edge = pix_en && st_q.sync_generator_enable && vs_act && !st_q.vs_prev;
    if (pix_en) begin
      st_d.hs_prev = hs_act;
      st_d.vs_prev = vs_act;
    end

    // RULE_05 field toggles only when interlaced
    if (vs_edge) begin
      st_d.gen_fid = st_q.mode.interlace ? !st_q.gen_fid : 1'b0;
    end
    st_d.field = st_q.mode.field_id_direction ? st_q.gen_fid : (st_q.fid_s[1] ^ st_q.mode.field_id_polarity);

    // RULE_21 shadow settings taken at vsync
    latch = vs_edge || !st_q.sync_generator_enable;
    if (latch) begin
      st_d.act = st_q.sh;
    end

    // RULE_09 direction and polarity of driven pins
    st_d.oe_s  = st_q.mode.sdir;
    st_d.oe_f  = st_q.mode.field_id_direction;
    st_d.o_hs  = gen_hs ^ st_q.mode.hpol;
    st_d.o_vs  = gen_vs ^ st_q.mode.vpol;
    st_d.o_fid = st_q.gen_fid ^ st_q.mode.field_id_polarity;

    // RULE_15 length truncated to a multiple of 16 pixels
    npix  = (16'(st_q.act.capture_line_length) + 16'h0001) & ~16'((1 << csw_pkg::WINDOW_ALIGN_LOG) - 1);
    // RULE_14 start pixel from hsync
    hwin  = st_q.hpos - 16'(st_q.act.capture_start_pixel);
    in_h  = (st_q.hpos >= 16'(st_q.act.capture_start_pixel)) && (hwin < npix);
    // RULE_16 per-field start line
    slv   = st_q.field ? st_q.act.start_line_field_one : st_q.act.start_line_field_zero;
    lwin  = st_q.vline - 16'(slv);
    // RULE_17 line count plus one
    in_v  = (st_q.vline >= 16'(slv)) && (lwin <= 16'(st_q.act.capture_line_count));
    // RULE_18 pixel mask by line parity
    hmask = lwin[0] ? st_q.act.horizontal_cull_mask[7:0] : st_q.act.horizontal_cull_mask[15:8];
    // RULE_19 RULE_27 masks indexed from window origin
    keep  = hmask[hwin[2:0]] && st_q.act.line_cull_mask[lwin[2:0]];
    // RULE_07 external write gate
    gate_ok = !(st_q.mode.extgate && st_q.sync_generator_enable) ||
              (st_q.wen_s[1] && (st_q.hs_s[1] ^ st_q.mode.hpol) && (st_q.vs_s[1] ^ st_q.mode.vpol));
    // RULE_24 write enable from active copy taken at vsync
    wr = pix_en && st_q.sync_generator_enable && st_q.act.memory_write_enable && in_h && in_v && keep && gate_ok &&
         (st_q.mode.fmt != csw_pkg::FMT_RSVD) && !hs_edge && !vs_edge;

    // RULE_06 ones' complement option
    inv_d = st_q.d_s2 ^ {DATA_W{st_q.mode.inv}};
    // RULE_02 quarter-half-quarter filter
    fsum  = (DATA_W+2)'(st_q.p2) + (DATA_W+2)'({st_q.p1, 1'b0}) + (DATA_W+2)'(inv_d);
    raw_d = st_q.act.lpf ? fsum[DATA_W+1:2] : inv_d;
    // RULE_04 shift clamped at four bits
    amt   = (st_q.mode.shift > csw_pkg::MAX_SHIFT) ? csw_pkg::MAX_SHIFT : st_q.mode.shift;
    // RULE_20 mirrored address within line
    off   = st_q.act.address_decrement ? (npix - 16'h0001 - 16'(st_q.wpos)) : 16'(st_q.wpos);
    if (pix_en) begin
      st_d.p1 = inv_d;
      st_d.p2 = st_q.p1;
    end

    // RULE_26 counters restart on active edges
    if (vs_edge) begin
      st_d.hpos      = 16'h0000;
      st_d.vline     = 16'h0000;
      st_d.base      = '0;
      st_d.wpos      = 15'h0000;
      st_d.line_used = 1'b0;
    end else if (hs_edge) begin
      st_d.hpos      = 16'h0000;
      st_d.vline     = st_q.vline + 16'h0001;
      st_d.wpos      = 15'h0000;
      st_d.line_used = 1'b0;
      // RULE_25 line pitch in 32-byte units
      if (st_q.line_used) begin
        st_d.base = st_q.base + ADDR_W'({st_q.act.lofst, 4'h0});
      end
    end else if (pix_en) begin
      st_d.hpos = st_q.hpos + 16'h0001;
    end

    st_d.mvalid = wr;
    if (wr) begin
      // RULE_03 format selects path
      st_d.mdata     = (st_q.mode.fmt == csw_pkg::FMT_RAW) ? (raw_d >> amt) : inv_d;
      st_d.maddr     = st_q.base + ADDR_W'(off);
      st_d.wpos      = st_q.wpos + 15'h0001;
      st_d.line_used = 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      st_q        <= '0;
      st_q.wait_q <= 1'b1;
      st_q.mode   <= csw_pkg::MODE_RESET;
      st_q.sh     <= csw_pkg::TIMING_RESET;
      st_q.act    <= csw_pkg::TIMING_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_avs_readdata    = st_q.rdata;
  assign o_avs_waitrequest = st_q.wait_q;
  assign o_hsync           = st_q.o_hs;
  assign o_hsync_oe        = st_q.oe_s;
  assign o_vsync           = st_q.o_vs;
  assign o_vsync_oe        = st_q.oe_s;
  assign o_field_id        = st_q.o_fid;
  assign o_field_id_oe     = st_q.oe_f;
  assign o_mem_valid       = st_q.mvalid;
  assign o_mem_data        = st_q.mdata;
  assign o_mem_addr        = st_q.maddr;

  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);

  property p_field_stat;
    ((i_avs_read && st_q.wait_q && i_avs_address == csw_pkg::OFF_MODE) |=>
      o_avs_readdata[15] == $past(st_q.field));
  endproperty
  a_field_stat: assert property (p_field_stat) else $error("field status readback wrong"); // RULE_01

  property p_fmt_reset;
    ($past(i_rst) && !i_rst) |-> st_q.mode.fmt == csw_pkg::FMT_YC8;
  endproperty
  a_fmt_reset: assert property (p_fmt_reset) else $error("format field reset value wrong"); // RULE_03

  property p_sync_oe;
    (bus_take && i_avs_write && i_avs_address == csw_pkg::OFF_MODE && i_avs_writedata[0]) |=>
      ##1 (o_hsync_oe && o_vsync_oe);
  endproperty
  a_sync_oe: assert property (p_sync_oe) else $error("sync pins not driven after direction set"); // RULE_09

  property p_hs_idle;
    (gen_on && st_q.hcnt > 16'(st_q.act.hsync_pulse_width)) |=> o_hsync == $past(st_q.mode.hpol);
  endproperty
  a_hs_idle: assert property (p_hs_idle) else $error("hsync active past its width"); // RULE_10

  property p_line_wrap;
    (gen_on && pix_en && st_q.hcnt == st_q.act.line_period_count) |=> st_q.hcnt == 16'h0000;
  endproperty
  a_line_wrap: assert property (p_line_wrap) else $error("line period not closed"); // RULE_12

  property p_shadow_hold;
    !latch |=> $stable(st_q.act);
  endproperty
  a_shadow_hold: assert property (p_shadow_hold) else $error("active settings changed between vsyncs"); // RULE_21

  property p_no_memory_write_enable;
    !st_q.act.memory_write_enable |=> !o_mem_valid;
  endproperty
  a_no_memory_write_enable: assert property (p_no_memory_write_enable) else $error("write without data write enable"); // RULE_24

  property p_ext_gate;
    (st_q.mode.extgate && st_q.sync_generator_enable && !st_q.wen_s[1]) |=> !o_mem_valid;
  endproperty
  a_ext_gate: assert property (p_ext_gate) else $error("write while external enable low"); // RULE_07

endmodule // csw_capture_window

/* core/csw_pkg.sv */
// Purpose: Shared constants and carriers of the sync and capture window block
// Assumes: Avalon-MM byte addresses, one 32-bit word per register
// Notes:   Mode bits 13..0 map straight onto csw_mode_t
package csw_pkg;

  localparam logic [7:0] OFF_SYNC_ENABLE = 8'h00;
  localparam logic [7:0] OFF_MODE        = 8'h04;
  localparam logic [7:0] OFF_HS_WIDTH    = 8'h08;
  localparam logic [7:0] OFF_VS_WIDTH    = 8'h0C;
  localparam logic [7:0] OFF_PIX_LINE    = 8'h10;
  localparam logic [7:0] OFF_HALF_LINES  = 8'h14;
  localparam logic [7:0] OFF_START_PIX   = 8'h18;
  localparam logic [7:0] OFF_LINE_LEN    = 8'h1C;
  localparam logic [7:0] OFF_START_LN0   = 8'h20;
  localparam logic [7:0] OFF_START_LN1   = 8'h24;
  localparam logic [7:0] OFF_LINE_CNT    = 8'h28;
  localparam logic [7:0] OFF_HCULL       = 8'h2C;
  localparam logic [7:0] OFF_VCULL       = 8'h30;
  localparam logic [7:0] OFF_LINE_SIZE   = 8'h34;

  localparam int MODE_FIELD_BIT   = 15;
  localparam int MODE_FILTER_BIT  = 14;
  localparam int SIZE_DECR_BIT    = 12;
  localparam int SYNC_MEMORY_WRITE_ENABLE_BIT    = 1;
  localparam int SYNC_SYNC_GENERATOR_ENABLE_BIT    = 0;
  localparam int WINDOW_ALIGN_LOG = 4;
  localparam int LINE_UNIT_LOG    = 4;
  localparam logic [2:0] MAX_SHIFT = 3'h4;

  typedef enum logic [1:0] {
    FMT_RAW   = 2'b00,
    FMT_YC16  = 2'b01,
    FMT_YC8   = 2'b10,
    FMT_RSVD  = 2'b11
  } csw_fmt_t;

  typedef struct packed {
    csw_fmt_t   fmt;
    logic       pad;
    logic [2:0] shift;
    logic       interlace;
    logic       inv;
    logic       extgate;
    logic       field_id_polarity;
    logic       hpol;
    logic       vpol;
    logic       field_id_direction;
    logic       sdir;
  } csw_mode_t;

  localparam csw_mode_t MODE_RESET = '{fmt: FMT_YC8, default: '0};

  typedef struct packed {
    logic        lpf;
    logic        memory_write_enable;
    logic [11:0] hsync_pulse_width;
    logic [11:0] vsync_pulse_width;
    logic [15:0] line_period_count;
    logic [15:0] frame_half_line_count;
    logic [14:0] capture_start_pixel;
    logic [14:0] capture_line_length;
    logic [14:0] start_line_field_zero;
    logic [14:0] start_line_field_one;
    logic [14:0] capture_line_count;
    logic [15:0] horizontal_cull_mask;
    logic [7:0]  line_cull_mask;
    logic        address_decrement;
    logic [11:0] lofst;
  } csw_timing_t;

  localparam csw_timing_t TIMING_RESET = '0;

  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } csw_avs_req_t;

endpackage

/* sim/csw_capture_window_bench.sv */
// Purpose: Self-checking bench of the sync and capture window block
// Assumes: Source lines of 40 pixels, 5 lines a frame, window lines 1 and 2
// Notes:   Pin level is the device output while its enable is high
`timescale 1ns/1ps
module csw_capture_window_bench;
  localparam logic [15:0] PAT = 16'hA5F0;
  typedef struct packed {
    logic [15:0] mode;
    logic [14:0] capture_line_length;
    logic [15:0] horizontal_cull_mask;
    logic [7:0]  line_cull_mask;
    logic [12:0] size;
    logic        neg;
    logic        wen;
    logic [7:0]  n;
  } csw_row_t;
  csw_row_t    rows [13] = '{
    '{16'h0000, 15'h000F, 16'hFFFF, 8'hFF, 13'h0000, 1'b0, 1'b1, 8'h20},
    '{16'h0400, 15'h000F, 16'hFFFF, 8'hFF, 13'h0000, 1'b0, 1'b1, 8'h20},
    '{16'h0040, 15'h000F, 16'hFFFF, 8'hFF, 13'h0000, 1'b0, 1'b1, 8'h20},
    '{16'h1400, 15'h000F, 16'hFFFF, 8'hFF, 13'h0000, 1'b0, 1'b1, 8'h20},
    '{16'h3000, 15'h000F, 16'hFFFF, 8'hFF, 13'h0000, 1'b0, 1'b1, 8'h00},
    '{16'h000C, 15'h000F, 16'hFFFF, 8'hFF, 13'h0000, 1'b1, 1'b1, 8'h20},
    '{16'h0000, 15'h001F, 16'hFFFF, 8'hFF, 13'h0000, 1'b0, 1'b1, 8'h40},
    '{16'h0000, 15'h000E, 16'hFFFF, 8'hFF, 13'h0000, 1'b0, 1'b1, 8'h00},
    '{16'h0000, 15'h000F, 16'h5555, 8'hFF, 13'h0000, 1'b0, 1'b1, 8'h10},
    '{16'h0000, 15'h000F, 16'hFF00, 8'hFF, 13'h0000, 1'b0, 1'b1, 8'h10},
    '{16'h0000, 15'h000F, 16'hFFFF, 8'h01, 13'h0000, 1'b0, 1'b1, 8'h10},
    '{16'h0020, 15'h000F, 16'hFFFF, 8'hFF, 13'h0000, 1'b0, 1'b0, 8'h00},
    '{16'h0000, 15'h000F, 16'hFFFF, 8'hFF, 13'h1000, 1'b0, 1'b1, 8'h20}};
  logic [31:0] msk [15] = '{32'h2, 32'h747E, 32'hFFF, 32'hFFF, 32'hFFFF, 32'hFFFF, 32'h7FFF,
    32'h7FFF, 32'h7FFF, 32'h7FFF, 32'h7FFF, 32'hFFFF, 32'hFF, 32'h1FFF, 32'hFFFF};
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic        neg = 1'b0;
  logic        field_id = 1'b0;
  logic        wen = 1'b1;
  logic        counting = 1'b0;
  logic [31:0] rdat, rv, ea;
  logic        wreq, pclk, m_hs, m_vs, sof, hs_o, hs_oe, vs_o, vs_oe, fi_o, fi_oe, mval;
  logic [15:0] pix, mdat, d0;
  logic [23:0] madr, a0;
  int          error_cnt = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          cnt = 0;
  int          pc = 0;
  wire         hs_w = hs_oe ? hs_o : m_hs;
  wire         vs_w = vs_oe ? vs_o : m_vs;
  wire         fi_w = fi_oe ? fi_o : field_id;

  csw_sensor_model #(.LPIX(40), .NLIN(5)) u_src (.i_neg(neg), .i_pat(PAT), .o_pclk(pclk),
    .o_hsync(m_hs), .o_vsync(m_vs), .o_sof(sof), .o_data(pix));
  csw_capture_window DUT (.i_clock(clk), .i_rst(rst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .o_avs_readdata(rdat), .o_avs_waitrequest(wreq),
    .i_pclk(pclk), .i_pix_data(pix), .i_ext_wen(wen), .i_hsync(hs_w), .o_hsync(hs_o),
    .o_hsync_oe(hs_oe), .i_vsync(vs_w), .o_vsync(vs_o), .o_vsync_oe(vs_oe), .i_field_id(fi_w),
    .o_field_id(fi_o), .o_field_id_oe(fi_oe), .o_mem_valid(mval), .o_mem_data(mdat),
    .o_mem_addr(madr));

  always #12.5 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 100000) begin
      error_cnt++;
      stop_test();
    end
  end
  // Sampled mid-cycle, away from the edge that moves the pulse
  always @(negedge clk) begin
    if (counting && mval === 1'b1) begin
      if (cnt == 0) begin
        d0 = mdat;
        a0 = madr;
      end
      cnt++;
    end
  end
  always @(posedge pclk) pc++;

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (wreq !== 1'b0);
    rv = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(name, e, rv);
  endtask
  function automatic logic [15:0] exp_dat(input logic [15:0] m);
    logic [15:0] v;
    v = m[6] ? ~PAT : PAT;
    return (m[13:12] == 2'b00) ? v >> m[10:8] : v;
  endfunction
  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    chk("oe", 32'h0, {29'h0, hs_oe, vs_oe, fi_oe});
    for (int i = 0; i < 15; i++) rchk("reset", 8'(i * 4), i == 1 ? 32'h2000 : 32'h0);
    for (int i = 0; i < 15; i++) bus(1'b1, 8'(i * 4), msk[i]);
    for (int i = 0; i < 15; i++) rchk("readback", 8'(i * 4), i == 14 ? 32'h0 : msk[i]);
    bus(1'b1, csw_pkg::OFF_START_PIX, 32'h2);
    bus(1'b1, csw_pkg::OFF_START_LN0, 32'h1);
    bus(1'b1, csw_pkg::OFF_START_LN1, 32'h1);
    bus(1'b1, csw_pkg::OFF_LINE_CNT, 32'h1);
    bus(1'b1, csw_pkg::OFF_SYNC_ENABLE, 32'h3);
    foreach (rows[r]) begin
      bus(1'b1, csw_pkg::OFF_MODE, {16'h0, rows[r].mode});
      bus(1'b1, csw_pkg::OFF_LINE_LEN, {17'h0, rows[r].capture_line_length});
      bus(1'b1, csw_pkg::OFF_HCULL, {16'h0, rows[r].horizontal_cull_mask});
      bus(1'b1, csw_pkg::OFF_VCULL, {24'h0, rows[r].line_cull_mask});
      bus(1'b1, csw_pkg::OFF_LINE_SIZE, {19'h0, rows[r].size});
      @(posedge clk);
      neg <= rows[r].neg;
      wen <= rows[r].wen;
      @(posedge sof);
      @(posedge sof);
      cnt = 0;
      counting = 1'b1;
      @(posedge sof);
      counting = 1'b0;
      ea = rows[r].size[12] ? {17'h0, (rows[r].capture_line_length + 15'h1) & 15'h7FF0} - 32'h1 : 32'h0;
      chk("count", {24'h0, rows[r].n}, cnt);
      if (cnt > 0) begin
        chk("data", {16'h0, exp_dat(rows[r].mode)}, {16'h0, d0});
        chk("addr", ea, {8'h0, a0});
      end
    end
    // Longer line written after frame start must wait for the next frame
    bus(1'b1, csw_pkg::OFF_LINE_SIZE, 32'h0);
    @(posedge sof);
    // Wait past the latch that this frame start causes inside the block
    repeat (2) @(posedge pclk);
    bus(1'b1, csw_pkg::OFF_LINE_LEN, 32'h1F);
    cnt = 0;
    counting = 1'b1;
    @(posedge sof);
    counting = 1'b0;
    chk("shadow", 32'h20, cnt);
    cnt = 0;
    counting = 1'b1;
    @(posedge sof);
    counting = 1'b0;
    chk("shadow_next", 32'h40, cnt);
    @(posedge clk);
    field_id <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      bus(1'b1, csw_pkg::OFF_MODE, p ? 32'h10 : 32'h0);
      repeat (4) @(posedge clk);
      rchk("field", csw_pkg::OFF_MODE, p ? 32'h0010 : 32'h8000);
    end
    // Generator stopped while timing loads, so each setting latches as soon as it is written
    bus(1'b1, csw_pkg::OFF_SYNC_ENABLE, 32'h0);
    bus(1'b1, csw_pkg::OFF_HS_WIDTH, 32'h2);
    bus(1'b1, csw_pkg::OFF_VS_WIDTH, 32'h0);
    bus(1'b1, csw_pkg::OFF_PIX_LINE, 32'h13);
    bus(1'b1, csw_pkg::OFF_HALF_LINES, 32'h9);
    bus(1'b1, csw_pkg::OFF_MODE, 32'h13);
    bus(1'b1, csw_pkg::OFF_SYNC_ENABLE, 32'h1);
    repeat (4) @(posedge clk);
    chk("oe", 32'h7, {29'h0, hs_oe, vs_oe, fi_oe});
    chk("fid", 32'h1, {31'h0, fi_o});
    @(posedge vs_o);
    pc = 0;
    @(posedge vs_o);
    chk("vperiod", 32'h64, pc);
    @(posedge hs_o);
    pc = 0;
    @(negedge hs_o);
    chk("hwidth", 32'h3, pc);
    @(posedge hs_o);
    chk("hperiod", 32'h14, pc);
    bus(1'b1, csw_pkg::OFF_MODE, 32'h93);
    @(posedge vs_o);
    repeat (16) @(posedge clk);
    bus(1'b0, csw_pkg::OFF_MODE, 32'h0);
    ea = rv;
    chk("interlace_mode", 32'h0093, ea & 32'h7FFF);
    @(posedge vs_o);
    repeat (16) @(posedge clk);
    rchk("interlace", csw_pkg::OFF_MODE, ea ^ 32'h8000);
    @(posedge clk);
    rst <= 1'b1;
    field_id <= 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk("reset2", csw_pkg::OFF_MODE, 32'h2000);
    stop_test();
  end
endmodule // csw_capture_window_bench

/* sim/csw_sensor_model.sv */
// Purpose: Pixel source with free pixel clock, syncs, frame-start marker and data
// Assumes: Sync active for one pixel per line and around each frame start
// Notes:   Outputs move on the falling pixel edge, steady at the rising one
`timescale 1ns/1ps
module csw_sensor_model #(
  parameter int LPIX = 40,
  parameter int NLIN = 5
) (
  input  wire logic        i_neg,
  input  wire logic [15:0] i_pat,
  output logic             o_pclk,
  output logic             o_hsync,
  output logic             o_vsync,
  output logic             o_sof,
  output logic [15:0]      o_data
);
  int px = 0;
  int ln = 0;
  // Odd start offset keeps pixel edges apart from system clock edges
  initial begin
    o_pclk = 1'b0;
    #37;
    forever #100 o_pclk = ~o_pclk;
  end
  always @(negedge o_pclk) begin
    px = (px == LPIX - 1) ? 0 : px + 1;
    if (px == 0) ln = (ln == NLIN - 1) ? 0 : ln + 1;
  end
  assign o_sof   = (ln == NLIN - 1) && (px >= 20);
  assign o_hsync = (px == 0) ^ i_neg;
  assign o_vsync = ((ln == NLIN - 1 && px >= 20) || (ln == 0 && px < 20)) ^ i_neg;
  assign o_data  = i_pat;
endmodule // csw_sensor_model
